// *** design/pmx_cfg.svh ***
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

// ----------------------------------------------------------------
// Pad counts and special pad positions
// ----------------------------------------------------------------
`define PMX_NPAD         57
`define PMX_NLCD_FULL    44
`define PMX_NLCD_RED     32
`define PMX_DBG_PAD      56
`define PMX_NALT         4
`define PMX_SER1_TX_PAD  44
`define PMX_SER2_TX_PAD  45
`define PMX_SER1_RX_PAD  46
`define PMX_SER2_RX_PAD  47
`define PMX_PCNT0_PAD    48
`define PMX_TX_ALT       3'h2
`define PMX_FSEL_MAX     3'h4

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PMX_OFS_DATA_LO  12'h000
`define PMX_OFS_DATA_HI  12'h004
`define PMX_OFS_DIR_LO   12'h008
`define PMX_OFS_DIR_HI   12'h00c
`define PMX_OFS_PULL_LO  12'h010
`define PMX_OFS_PULL_HI  12'h014
`define PMX_OFS_FILT_LO  12'h018
`define PMX_OFS_FILT_HI  12'h01c
`define PMX_OFS_DRV_LO   12'h020
`define PMX_OFS_DRV_HI   12'h024
`define PMX_OFS_SLEW_LO  12'h028
`define PMX_OFS_SLEW_HI  12'h02c
`define PMX_OFS_SYSOPT   12'h030
`define PMX_OFS_ROUTE    12'h034
`define PMX_OFS_FSEL0    12'h040
`define PMX_NFSEL_WORDS  8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PMX_SO_DBG_EN    0
`define PMX_SO_LCD_EN    1
`define PMX_SO_LCD_OD    2
`define PMX_SO_LCD_FULL  3
`define PMX_RT_RX_CMP    0
`define PMX_RT_TX_MOD    2
`define PMX_RT_TX_TSEL   4
`define PMX_RT_PULSE_COUNTER_INPUT_CMP  6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PMX_RST_DBG_EN   1'b1
`define PMX_RST_LCD_FULL 1'b1

`endif

// *** design/pmx_pkg.sv ***
`include "pmx_cfg.svh"

package pmx_pkg;

    // Per-pad bit vector
    typedef logic [`PMX_NPAD-1:0] pmx_pads_t;

    // Per-pad function selector, 0 = default function
    typedef logic [`PMX_NPAD-1:0][2:0] pmx_fsel_t;

    // Alternate function drives from peripherals
    typedef struct packed {
        logic [`PMX_NALT-1:0][`PMX_NPAD-1:0] out;
        logic [`PMX_NALT-1:0][`PMX_NPAD-1:0] oe;
    } pmx_alt_t;

    // Pad cell controls
    typedef struct packed {
        pmx_pads_t out;
        pmx_pads_t oe;
        pmx_pads_t pu;
        pmx_pads_t filt;
        pmx_pads_t ds;
        pmx_pads_t slew;
    } pmx_pad_ctl_t;

    // Signal routing sources
    typedef struct packed {
        logic [1:0] ser_tx;
        logic [1:0] cmp_rx;
        logic [1:0] timer;
        logic [2:0] cmp_pulse_counter_input;
    } pmx_route_in_t;

endpackage

// *** design/pmx_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmx_cfg.svh"

module pmx_top
    import pmx_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          deep_stop_wake,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic [56:0]   pad_in,
    output pmx_pad_ctl_t       pad_ctl,
    output logic      [56:0]   pad_in_sync,
    input  wire pmx_alt_t      alt_drv,
    input  wire logic [43:0]   lcd_seg_out,
    input  wire logic [43:0]   lcd_seg_oe,
    input  wire logic          dbg_out,
    input  wire logic          dbg_oe,
    input  wire pmx_route_in_t route_in,
    output logic      [1:0]    ser_rx,
    output logic      [2:0]    pulse_counter_input_in,
    output logic               lcd_enabled,
    output logic               debug_pin_enable
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pmx_pads_t    data;       // Port output latch
        pmx_pads_t    dir;        // 1 = output
        pmx_pads_t    pull;       // Pull-up request
        pmx_pads_t    filt;       // Input filter enable
        pmx_pads_t    drv;        // High drive strength
        pmx_pads_t    slew;       // Slew limiting enable
        pmx_fsel_t    fsel;       // Function selector
        logic         dbg_en;     // Debug pad owns the pin
        logic         lcd_en;     // LCD drives its pads
        logic         lcd_od;     // LCD pads as open drain
        logic         lcd_full;   // 44 line configuration
        logic [1:0]   rx_cmp;     // Receive from comparator
        logic [1:0]   tx_mod;     // Transmit modulation enable
        logic [1:0]   tx_tsel;    // Timer source per port
        logic [2:0]   pulse_counter_input_cmp;   // Counter from comparator
        pmx_pads_t    in_s1;      // First sync stage
        pmx_pads_t    in_s2;      // Second sync stage
        logic [31:0]  rdata;      // Bus read data
        logic         ready;      // Bus access answer
        logic         err;        // Unmapped access
        pmx_pad_ctl_t ctl;        // Registered pad controls
        logic [1:0]   rx;         // Routed receive
        logic [2:0]   pulse_counter_input;       // Routed counter inputs
        logic [4:0]   cmp_s1;     // First comparator stage
        logic [4:0]   cmp_s2;     // Second comparator stage
    } pmx_state_t;

    pmx_state_t st_q;
    pmx_state_t st_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Read one 32-bit half of a pad vector
    function automatic logic [31:0] pmx_rd_half(input pmx_pads_t v, input logic hi);
        logic [63:0] w;
        w = {7'h00, v};
        return hi ? w[63:32] : w[31:0];
    endfunction

    // Write one 32-bit half of a pad vector
    function automatic pmx_pads_t pmx_wr_half(input pmx_pads_t v, input logic hi,
                                              input logic [31:0] wd);
        logic [63:0] w;
        w = {7'h00, v};
        if (hi) begin
            w[63:32] = wd;
        end else begin
            w[31:0] = wd;
        end
        return w[`PMX_NPAD-1:0];
    endfunction

    // Does this offset hit a pad vector register pair
    function automatic logic pmx_is_vec(input logic [11:0] a);
        return (a <= `PMX_OFS_SLEW_HI) && (a[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic        setup;
        logic        access;
        logic        hit;
        logic        hi;
        logic [31:0] rd;
        logic [3:0]  fw;
        int          pad;
        int          nlcd;
        logic        shared;
        logic        out_mode;
        logic [2:0]  sel;
        pmx_pads_t   port_rd;
        pmx_alt_t    alt;

        st_d   = st_q;
        setup  = psel && !penable;
        access = psel && penable && st_q.ready;
        hi     = paddr[2];
        rd     = 32'h0000_0000;
        hit    = 1'b1;
        fw     = paddr[5:2] - 4'h0;
        // No latches
        pad    = 0;
        nlcd   = 0;
        shared = 1'b0;
        out_mode = 1'b0;
        sel    = 3'h0;
        port_rd = '0;
        alt    = '0;

        // Synchronise pad inputs; stage one feeds stage two only
        st_d.in_s1 = pad_in;
        st_d.in_s2 = st_q.in_s1;
        // Comparators are async
        st_d.cmp_s1 = {route_in.cmp_pulse_counter_input, route_in.cmp_rx};
        st_d.cmp_s2 = st_q.cmp_s1;

        // Port read: pad level for inputs, latch for outputs
        port_rd = (st_q.dir & st_q.data) | (~st_q.dir & st_q.in_s2);

        // Address decode and read mux
        if (pmx_is_vec(paddr)) begin
            // Top bits of HI read zero
            case (paddr[5:3])
                3'h0:    rd = pmx_rd_half(port_rd, hi);
                3'h1:    rd = pmx_rd_half(st_q.dir, hi);
                3'h2:    rd = pmx_rd_half(st_q.pull, hi);
                3'h3:    rd = pmx_rd_half(st_q.filt, hi);
                3'h4:    rd = pmx_rd_half(st_q.drv, hi);
                default: rd = pmx_rd_half(st_q.slew, hi);
            endcase
        end else if (paddr == `PMX_OFS_SYSOPT) begin
            rd[`PMX_SO_DBG_EN]   = st_q.dbg_en;
            rd[`PMX_SO_LCD_EN]   = st_q.lcd_en;
            rd[`PMX_SO_LCD_OD]   = st_q.lcd_od;
            rd[`PMX_SO_LCD_FULL] = st_q.lcd_full;
        end else if (paddr == `PMX_OFS_ROUTE) begin
            rd[`PMX_RT_RX_CMP+:2]   = st_q.rx_cmp;
            rd[`PMX_RT_TX_MOD+:2]   = st_q.tx_mod;
            rd[`PMX_RT_TX_TSEL+:2]  = st_q.tx_tsel;
            rd[`PMX_RT_PULSE_COUNTER_INPUT_CMP+:3] = st_q.pulse_counter_input_cmp;
        end else if (paddr[11:5] == `PMX_OFS_FSEL0 >> 5 && paddr[1:0] == 2'b00) begin
            // Eight pads per word, four bits per pad
            fw = {1'b0, paddr[4:2]};
            for (int j = 0; j < 8; j++) begin
                pad = 8 * int'(fw) + j;
                // Last word partly used
                if (pad < `PMX_NPAD) begin
                    rd[4*j+:3] = st_q.fsel[pad];
                end
            end
        end else begin
            // Unmapped: reads zero and flags an error
            hit = 1'b0;
        end

        // Answer one cycle after setup, zero wait states
        st_d.ready = setup;
        if (setup) begin
            st_d.rdata = rd;
            st_d.err   = !hit;
        end else if (access) begin
            st_d.rdata = 32'h0000_0000;
            st_d.err   = 1'b0;
        end

        // Writes take effect at the end of the access phase
        if (access && pwrite && hit) begin
            if (pmx_is_vec(paddr)) begin
                case (paddr[5:3])
                    3'h0:    st_d.data = pmx_wr_half(st_q.data, hi, pwdata);
                    3'h1:    st_d.dir  = pmx_wr_half(st_q.dir, hi, pwdata);
                    3'h2:    st_d.pull = pmx_wr_half(st_q.pull, hi, pwdata);
                    3'h3:    st_d.filt = pmx_wr_half(st_q.filt, hi, pwdata);
                    3'h4:    st_d.drv  = pmx_wr_half(st_q.drv, hi, pwdata);
                    default: st_d.slew = pmx_wr_half(st_q.slew, hi, pwdata);
                endcase
            end else if (paddr == `PMX_OFS_SYSOPT) begin
                st_d.dbg_en   = pwdata[`PMX_SO_DBG_EN];
                st_d.lcd_en   = pwdata[`PMX_SO_LCD_EN];
                st_d.lcd_od   = pwdata[`PMX_SO_LCD_OD];
                st_d.lcd_full = pwdata[`PMX_SO_LCD_FULL];
            end else if (paddr == `PMX_OFS_ROUTE) begin
                st_d.rx_cmp   = pwdata[`PMX_RT_RX_CMP+:2];
                st_d.tx_mod   = pwdata[`PMX_RT_TX_MOD+:2];
                st_d.tx_tsel  = pwdata[`PMX_RT_TX_TSEL+:2];
                st_d.pulse_counter_input_cmp = pwdata[`PMX_RT_PULSE_COUNTER_INPUT_CMP+:3];
            end else begin
                for (int j = 0; j < 8; j++) begin
                    pad = 8 * int'(paddr[4:2]) + j;
                    // Codes above four are ignored, the selector keeps its value
                    if (pad < `PMX_NPAD && pwdata[4*j+:3] <= `PMX_FSEL_MAX) begin
                        st_d.fsel[pad] = pwdata[4*j+:3];
                    end
                end
            end
        end

        // Routed transmit replaces the peripheral's transmit drive; modulation gates it with the selected timer
        alt = alt_drv;
        for (int k = 0; k < 2; k++) begin
            pad = (k == 0) ? `PMX_SER1_TX_PAD : `PMX_SER2_TX_PAD;
            alt.out[`PMX_TX_ALT - 3'h1][pad] = st_q.tx_mod[k]
                ? (route_in.ser_tx[k] & route_in.timer[st_q.tx_tsel[k]])
                : route_in.ser_tx[k];
        end

        // Pad ownership, decided here and nowhere else
        nlcd = st_q.lcd_full ? `PMX_NLCD_FULL : `PMX_NLCD_RED;
        for (int i = 0; i < `PMX_NPAD; i++) begin
            shared   = (i < `PMX_NLCD_FULL);
            sel      = st_q.fsel[i];
            out_mode = st_q.dir[i];
            st_d.ctl.filt[i] = st_q.filt[i];
            st_d.ctl.ds[i]   = st_q.drv[i];
            st_d.ctl.slew[i] = st_q.slew[i];
            if (st_q.lcd_en && i < nlcd) begin
                // LCD driver owns the pad
                st_d.ctl.out[i] = lcd_seg_out[i];
                st_d.ctl.oe[i]  = lcd_seg_oe[i];
                st_d.ctl.pu[i]  = 1'b0;
            end else if (i == `PMX_DBG_PAD && st_q.dbg_en) begin
                // Debug pad: bidirectional, pull-up on automatically
                st_d.ctl.out[i] = dbg_out;
                st_d.ctl.oe[i]  = dbg_oe;
                st_d.ctl.pu[i]  = 1'b1;
            end else if (sel == 3'h0) begin
                // Port function; LCD off leaves shared pads here
                st_d.ctl.out[i] = st_q.data[i];
                st_d.ctl.oe[i]  = out_mode;
                if (shared && st_q.lcd_od) begin
                    // Open drain chosen by LCD config, not the port
                    st_d.ctl.out[i] = 1'b0;
                    st_d.ctl.oe[i]  = out_mode && !st_q.data[i];
                    st_d.ctl.pu[i]  = st_q.pull[i];
                end else begin
                    // Pull-up only while the pad is an input
                    st_d.ctl.pu[i]  = st_q.pull[i] && !out_mode;
                end
                if (i == `PMX_DBG_PAD) begin
                    // Output-only as a port pin
                    st_d.ctl.oe[i] = 1'b1;
                    st_d.ctl.pu[i] = 1'b0;
                end
            end else begin
                // Alternate function drives the buffer
                st_d.ctl.out[i] = alt.out[sel - 3'h1][i];
                st_d.ctl.oe[i]  = alt.oe[sel - 3'h1][i];
                st_d.ctl.pu[i]  = st_q.pull[i] && !alt.oe[sel - 3'h1][i];
            end
        end

        // Receive and counter routing
        st_d.rx[0] = st_q.rx_cmp[0] ? st_q.cmp_s2[0]
                                    : st_q.in_s2[`PMX_SER1_RX_PAD];
        st_d.rx[1] = st_q.rx_cmp[1] ? st_q.cmp_s2[1]
                                    : st_q.in_s2[`PMX_SER2_RX_PAD];
        for (int c = 0; c < 3; c++) begin
            st_d.pulse_counter_input[c] = st_q.pulse_counter_input_cmp[c] ? st_q.cmp_s2[2 + c]
                                            : st_q.in_s2[`PMX_PCNT0_PAD + c];
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Synchronous reset; LCD enable and LCD open drain survive a deep-stop wake only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.dbg_en   <= `PMX_RST_DBG_EN;
            // Default is 44 lines
            st_q.lcd_full <= `PMX_RST_LCD_FULL;
            // Only a wake keeps the display
            st_q.lcd_en   <= deep_stop_wake & st_q.lcd_en;
            st_q.lcd_od   <= deep_stop_wake & st_q.lcd_od;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Flops only, no logic
    assign prdata           = st_q.rdata;
    assign pready           = st_q.ready;
    assign pslverr          = st_q.err;
    assign pad_ctl          = st_q.ctl;
    assign pad_in_sync      = st_q.in_s2;
    assign ser_rx           = st_q.rx;
    assign pulse_counter_input_in          = st_q.pulse_counter_input;
    assign lcd_enabled      = st_q.lcd_en;
    assign debug_pin_enable = st_q.dbg_en;

endmodule

`default_nettype wire

// *** tb/pmx_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmx_top_monitor
    import pmx_pkg::*;
(
    input wire logic         clk,
    input wire logic         sys_rst,
    input wire logic         deep_stop_wake,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic [56:0]  pad_in,
    input wire pmx_pad_ctl_t pad_ctl,
    input wire logic [56:0]  pad_in_sync,
    input wire logic [43:0]  lcd_seg_out,
    input wire logic [43:0]  lcd_seg_oe,
    input wire logic         dbg_oe,
    input wire logic         lcd_enabled,
    input wire logic         debug_pin_enable
);

    // ----------------------------------------------------------------
    // Single domain: every property samples on the bus clock
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    // Reset always brings the debug pad back
    AST_RST_DBG: assert property (sys_rst |=> debug_pin_enable)
        else $error("debug enable not set by reset");
    // Plain reset clears the display enable
    AST_RST_LCD: assert property (sys_rst && !deep_stop_wake |=> !lcd_enabled)
        else $error("lcd enable survived a plain reset");
    // Deep-stop wake keeps a running display
    AST_WAKE_LCD: assert property (sys_rst && deep_stop_wake && lcd_enabled |=> lcd_enabled)
        else $error("lcd enable lost on wake");
    // Pads land as undriven inputs, pulls off, one edge after state
    AST_RST_PADS: assert property (sys_rst && !deep_stop_wake |=> ##1
        (pad_ctl.oe[55:0] == '0 && pad_ctl.pu[55:0] == '0))
        else $error("pad not released after reset");
    // Pad levels reach the sync outputs two edges later
    AST_SYNC: assert property (disable iff (sys_rst)
        !$past(sys_rst) && !$past(sys_rst, 2) |-> pad_in_sync == $past(pad_in, 2))
        else $error("pad sync path delay wrong");
    // Debug function owns the pad, with its pull-up on
    AST_DBG_PAD: assert property (disable iff (sys_rst) $past(debug_pin_enable) && !$past(sys_rst)
        |-> pad_ctl.oe[56] == $past(dbg_oe) && pad_ctl.pu[56])
        else $error("debug pad not driven by debug function");
    // Line 31 exists in both display sizes; low segments drive low
    AST_LCD_LINE: assert property (disable iff (sys_rst)
        $past(lcd_enabled) && !$past(sys_rst) && !$past(lcd_seg_out[31])
        |-> pad_ctl.oe[31] == $past(lcd_seg_oe[31]) && !pad_ctl.out[31])
        else $error("display line not routed to its pad");
    // Zero wait states: answer in the first access cycle
    AST_ACCESS: assert property (disable iff (sys_rst) psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    // Ready is a single-cycle pulse
    AST_PULSE: assert property (disable iff (sys_rst) pready |=> !pready)
        else $error("ready held too long");
    // Refused reads return zero
    AST_ERR_ZERO: assert property (disable iff (sys_rst)
        pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");

endmodule

bind pmx_top pmx_top_monitor u_mon (
    .clk(clk), .sys_rst(sys_rst), .deep_stop_wake(deep_stop_wake), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pad_in(pad_in), .pad_ctl(pad_ctl), .pad_in_sync(pad_in_sync),
    .lcd_seg_out(lcd_seg_out), .lcd_seg_oe(lcd_seg_oe), .dbg_oe(dbg_oe),
    .lcd_enabled(lcd_enabled), .debug_pin_enable(debug_pin_enable)
);

`default_nettype wire

// *** tb/pmx_pad_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pmx_pad_model
    import pmx_pkg::*;
(
    input  wire logic         clk,
    input  wire pmx_pad_ctl_t pad_ctl,
    input  wire logic [56:0]  ext_en,
    input  wire logic [56:0]  ext_val,
    output logic      [56:0]  pad_in
);

    // ----------------------------------------------------------------
    // Floating pads
    // ----------------------------------------------------------------
    // An open pad wanders, so it never settles to a friendly value
    logic [56:0] churn_q = 57'h0;

    always_ff @(posedge clk) begin
        churn_q <= ~churn_q;
    end

    // ----------------------------------------------------------------
    // Pin level: own drive, then outside driver, then pull-up
    // ----------------------------------------------------------------
    // Unused pads rely on the pull-up to stop floating
    assign pad_in = (pad_ctl.oe & pad_ctl.out)
                  | (~pad_ctl.oe & ext_en & ext_val)
                  | (~pad_ctl.oe & ~ext_en & pad_ctl.pu)
                  | (~pad_ctl.oe & ~ext_en & ~pad_ctl.pu & churn_q);

endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmx_cfg.svh"

module tb_top
    import pmx_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------------------------------
    logic          clk = 1'b0;
    logic          sys_rst, deep_stop_wake, psel, penable, pwrite, pready, pslverr;
    logic          dbg_out, dbg_oe, lcd_enabled, debug_pin_enable, err;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rdv;
    logic [56:0]   pad_in, pad_in_sync, ext_en, ext_val;
    logic [43:0]   lcd_seg_out, lcd_seg_oe;
    logic [1:0]    ser_rx;
    logic [2:0]    pulse_counter_input_in;
    pmx_pad_ctl_t  pad_ctl;
    pmx_alt_t      alt_drv;
    pmx_route_in_t route_in;
    int            n_mismatch, checked;

    always #12.5 clk = ~clk;

    pmx_top uut (.clk(clk), .sys_rst(sys_rst), .deep_stop_wake(deep_stop_wake), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_ctl(pad_ctl),
        .pad_in_sync(pad_in_sync), .alt_drv(alt_drv), .lcd_seg_out(lcd_seg_out),
        .lcd_seg_oe(lcd_seg_oe), .dbg_out(dbg_out), .dbg_oe(dbg_oe), .route_in(route_in),
        .ser_rx(ser_rx), .pulse_counter_input_in(pulse_counter_input_in), .lcd_enabled(lcd_enabled),
        .debug_pin_enable(debug_pin_enable));

    pmx_pad_model u_pads (.clk(clk), .pad_ctl(pad_ctl), .ext_en(ext_en), .ext_val(ext_val),
        .pad_in(pad_in));

    // ----------------------------------------------------------------
    // Reporting and bus tasks
    // ----------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH pready expected 1 seen %b", pready);
            wrap_up();
        end else begin
            rdv = prdata;
            err = pslverr;
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, {32'h0, e}, {32'h0, rdv});
    endtask

    // Register to pad takes one edge; pad to routed input three
    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic do_rst(input logic wake);
        @(posedge clk);
        sys_rst <= 1'b1; deep_stop_wake <= wake;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0; deep_stop_wake <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1; deep_stop_wake = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; dbg_out = 1'b0; dbg_oe = 1'b0;
        ext_en = '0; ext_val = '0; lcd_seg_out = '0; lcd_seg_oe = '1;
        route_in = '0; n_mismatch = 0; checked = 0;
        for (int j = 0; j < 4; j++) begin
            alt_drv.out[j] = {57{j[0] == 1'b0}};
            alt_drv.oe[j] = '1;
        end
        do_rst(1'b0);
        // Reset state of registers and pads
        rdc("sysopt", `PMX_OFS_SYSOPT, 32'h0000_0009);
        rdc("route", `PMX_OFS_ROUTE, 32'h0);
        rdc("fsel", `PMX_OFS_FSEL0, 32'h0);
        rdc("dir", `PMX_OFS_DIR_LO, 32'h0);
        rdc("pull", `PMX_OFS_PULL_LO, 32'h0);
        chk("oe_rst", 64'h0, {8'h0, pad_ctl.oe[55:0]});
        chk("pu_rst", 64'h0, {8'h0, pad_ctl.pu[55:0]});
        apb(1'b0, 12'h03c, 32'h0);
        chk("slverr", 64'h1, {63'h0, err});
        // Output pad 5 strong and slow, input 6 pulled and filtered, input 7 driven from outside
        wr(`PMX_OFS_DIR_LO, 32'h20);
        wr(`PMX_OFS_DATA_LO, 32'h20);
        wr(`PMX_OFS_DRV_LO, 32'h20);
        wr(`PMX_OFS_SLEW_LO, 32'h20);
        wr(`PMX_OFS_PULL_LO, 32'h60);
        wr(`PMX_OFS_FILT_LO, 32'h40);
        ext_en[7] <= 1'b1; ext_val[7] <= 1'b1;
        settle();
        chk("gpio_out", 64'hf, {60'h0, pad_ctl.oe[5], pad_ctl.out[5], pad_ctl.ds[5],
            pad_ctl.slew[5]});
        chk("pp_pull", 64'h0, {63'h0, pad_ctl.pu[5]});
        chk("gpio_in", 64'h3, {62'h0, pad_ctl.pu[6], pad_ctl.filt[6]});
        apb(1'b0, `PMX_OFS_DATA_LO, 32'h0);
        chk("data_rd", 64'he0, {32'h0, rdv & 32'he0});
        // Display sizes; in the reduced size the top pads stay usable as port pins
        wr(`PMX_OFS_SYSOPT, 32'hb);
        settle();
        chk("lcd_full", 64'h3, {62'h0, lcd_enabled, pad_ctl.oe[43]});
        wr(`PMX_OFS_SYSOPT, 32'h3);
        settle();
        chk("lcd_red", 64'h1, {62'h0, pad_ctl.oe[43], pad_ctl.oe[31]});
        wr(`PMX_OFS_SYSOPT, 32'h1);
        settle();
        chk("lcd_off", 64'h1, {62'h0, pad_ctl.oe[31], pad_ctl.oe[5]});
        // Open-drain shared pads: high releases, pull stays
        wr(`PMX_OFS_SYSOPT, 32'h5);
        settle();
        chk("od_high", 64'h1, {62'h0, pad_ctl.oe[5], pad_ctl.pu[5]});
        wr(`PMX_OFS_DATA_LO, 32'h0);
        settle();
        chk("od_low", 64'h2, {62'h0, pad_ctl.oe[5], pad_ctl.out[5]});
        wr(`PMX_OFS_SYSOPT, 32'h1);
        // Alternate selectors 1..4 on pad 10, then a refused code
        for (int k = 1; k <= 5; k++) begin
            wr(`PMX_OFS_FSEL0 + 12'h004, 32'(k) << 8);
            settle();
            chk("alt_sel", {62'h0, 1'b1, k[0] == 1'b1 && k != 5}, {62'h0, pad_ctl.oe[10],
                pad_ctl.out[10]});
        end
        // Receive and counter inputs: pad first, then comparator
        ext_en[46] <= 1'b1; ext_val[46] <= 1'b1; ext_en[48] <= 1'b1; ext_val[48] <= 1'b1;
        settle();
        chk("rx_pad", 64'h3, {62'h0, ser_rx[0], pulse_counter_input_in[0]});
        wr(`PMX_OFS_ROUTE, 32'h41);
        settle();
        chk("rx_cmp0", 64'h0, {62'h0, ser_rx[0], pulse_counter_input_in[0]});
        route_in.cmp_rx[0] <= 1'b1; route_in.cmp_pulse_counter_input[0] <= 1'b1;
        settle();
        chk("rx_cmp1", 64'h3, {62'h0, ser_rx[0], pulse_counter_input_in[0]});
        // Transmit pad 44 on alternate 2, plain then gated by a timer
        wr(`PMX_OFS_FSEL0 + 12'h014, 32'h2 << 16);
        wr(`PMX_OFS_ROUTE, 32'h0);
        route_in.ser_tx <= 2'b01;
        settle();
        chk("tx_plain", 64'h1, {63'h0, pad_ctl.out[44]});
        wr(`PMX_OFS_ROUTE, 32'h4);
        settle();
        chk("tx_mod0", 64'h0, {63'h0, pad_ctl.out[44]});
        route_in.timer <= 2'b01;
        settle();
        chk("tx_mod1", 64'h1, {63'h0, pad_ctl.out[44]});
        wr(`PMX_OFS_ROUTE, 32'h14);
        settle();
        chk("tx_tsel", 64'h0, {63'h0, pad_ctl.out[44]});
        // Debug pad becomes an output-only port pin
        wr(`PMX_OFS_SYSOPT, 32'h0);
        settle();
        chk("dbg_off", 64'h1, {62'h0, debug_pin_enable, pad_ctl.oe[56]});
        // Wake keeps the display, plain reset drops it
        wr(`PMX_OFS_SYSOPT, 32'h2);
        do_rst(1'b1);
        chk("wake", 64'h3, {62'h0, lcd_enabled, debug_pin_enable});
        do_rst(1'b0);
        chk("cold", 64'h1, {62'h0, lcd_enabled, debug_pin_enable});
        wrap_up();
    end

endmodule

`default_nettype wire
